// file: design/monitor_sequencer.sv
// conversion sequencer, result registers and limit flags of the monitor
`include "monitor_defines.svh"
module monitor_sequencer #(
  parameter int INT_CONV_CYCLES = int'(`INT_CONV_US * 1000.0 / `CLK_PERIOD_NS),
  parameter int EXT_CONV_CYCLES = int'(`EXT_CONV_MS * 1000000.0 / `CLK_PERIOD_NS),
  parameter int SUPPLY_CONV_CYCLES = int'(`SUPPLY_CONV_US * 1000.0 / `CLK_PERIOD_NS),
  parameter int AVG_SAMPLES = 16
) (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  output logic [7:0] reg_rdata,
  input wire logic txn_active,
  output logic adc_convert,
  output logic adc_reset,
  output monitor_pkg::channel_type adc_channel,
  input wire logic [9:0] adc_data,
  input wire logic signed [7:0] int_limit_high,
  input wire logic signed [7:0] int_limit_low,
  input wire logic signed [7:0] ext_limit_high,
  input wire logic signed [7:0] ext_limit_low,
  input wire logic [7:0] supply_limit_high,
  input wire logic [7:0] supply_limit_low,
  input wire logic [3:0] temp_flag_mask,
  input wire logic [1:0] supply_flag_mask,
  input wire logic alert_active_high,
  output logic alert,
  output logic [9:0] dac_a_code,
  output logic [9:0] dac_b_code,
  output logic dac_a_load,
  output logic dac_b_load
);
  import monitor_pkg::*;
  localparam int CW = 20;

  initial begin
    if (INT_CONV_CYCLES < 1 || EXT_CONV_CYCLES < 1 || SUPPLY_CONV_CYCLES < 1)
      $error("conversion times must be at least one cycle");
    if (INT_CONV_CYCLES >= (1 << CW) || EXT_CONV_CYCLES >= (1 << CW) ||
        SUPPLY_CONV_CYCLES >= (1 << CW))
      $error("conversion time exceeds counter width");
  end

  // reset release through two flops
  logic rst_meta, rst_n;
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // software registers
  logic [7:0] config1, mode_ctrl, config3, int_offset, ext_offset;
  // result and flag registers
  logic [7:0] int_high_byte, ext_high_byte, supply_high_byte;
  logic [1:0] int_low_bits, ext_low_bits, supply_low_bits;
  logic [3:0] temp_flags;
  logic [1:0] supply_flags;

  // sequencer state
  seq_state_type state, next_state;
  channel_type channel, next_channel;
  logic [CW-1:0] conv_count;
  logic [9:0] sample;

  // control decode
  wire monitor_en = config1[`BIT_MONITOR_EN];
  wire single_channel_sel = mode_ctrl[`BIT_SINGLE_CHANNEL];
  wire avg_enable = ~mode_ctrl[`BIT_AVG_DISABLE];
  wire channel_sel_lsb = mode_ctrl[0];
  wire channel_sel_mid = mode_ctrl[1];
  wire run = monitor_en && !txn_active;
  wire write_hit = reg_write && !reg_read;

  // channel that the next conversion uses
  channel_type sel_channel;
  assign sel_channel = !channel_sel_mid && !channel_sel_lsb ? ch_supply :
                       !channel_sel_mid ? ch_internal : ch_external;
  channel_type rr_next;
  assign rr_next = (channel == ch_supply) ? ch_internal :
                   (channel == ch_internal) ? ch_external : ch_supply;

  // conversion length per channel
  logic [CW-1:0] conv_len;
  assign conv_len = (channel == ch_internal) ? CW'(INT_CONV_CYCLES) :
                    (channel == ch_external) ? CW'(EXT_CONV_CYCLES) :
                    CW'(SUPPLY_CONV_CYCLES);
  wire conv_end = (state == st_conv) && (conv_count == conv_len - 1'b1);
  wire is_temp = (channel != ch_supply);

  // averaging of temperature conversions
  logic avg_last;
  logic signed [9:0] avg_mean;
  sample_averager #(
    .SAMPLES(AVG_SAMPLES),
    .WIDTH(10)
  ) u_avg (
    .clk(ref_clk),
    .rst_n(rst_n),
    .clear(!run || state == st_idle || !avg_enable),
    .add(conv_end && is_temp && avg_enable),
    .sample(adc_data),
    .last(avg_last),
    .mean(avg_mean)
  );

  // a result is ready at each conversion end, or for averaged temperatures once the averaging window is complete
  wire result_ready = conv_end && (!is_temp || !avg_enable || avg_last);
  wire signed [9:0] next_result = (is_temp && avg_enable) ? avg_mean : adc_data;

  // state transitions
  always_comb begin
    next_state = state;
    next_channel = channel;
    unique case (state)
      st_idle: begin
        if (run) begin
          next_state = st_conv;
          next_channel = single_channel_sel ? sel_channel : channel;
        end
      end
      st_conv: begin
        if (!run) begin
          next_state = st_idle;
        end else if (result_ready) begin
          next_state = st_store;
        end
      end
      st_store: begin
        if (!run) begin
          next_state = st_idle;
        end else begin
          next_state = st_conv;
          next_channel = single_channel_sel ? sel_channel : rr_next;
        end
      end
      default: begin
        next_state = st_idle;
      end
    endcase
  end

  // round robin starts on supply after reset
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      state <= st_idle;
      channel <= ch_supply;
    end else begin
      state <= next_state;
      channel <= next_channel;
    end
  end

  // conversion timer restarts with each conversion
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      conv_count <= '0;
    end else if (state != st_conv || conv_end || !run) begin
      conv_count <= '0;
    end else begin
      conv_count <= conv_count + 1'b1;
    end
  end

  // hold the finished result for the store cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sample <= '0;
    end else if (result_ready) begin
      sample <= next_result;
    end
  end

  // adc control pins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      adc_convert <= 1'b0;
      adc_reset <= 1'b1;
      adc_channel <= ch_supply;
    end else begin
      adc_convert <= (next_state == st_conv);
      adc_reset <= !run;
      adc_channel <= next_channel;
    end
  end

  // limit comparison: temperatures in quarter degrees as signed 10-bit results, supply on its unsigned high byte
  wire storing = (state == st_store) && run;
  wire signed [9:0] temp_val = sample;
  wire signed [9:0] ih = {int_limit_high, 2'b00};
  wire signed [9:0] il = {int_limit_low, 2'b00};
  wire signed [9:0] eh = {ext_limit_high, 2'b00};
  wire signed [9:0] el = {ext_limit_low, 2'b00};
  wire [3:0] temp_hits = {
    (channel == ch_external) && (temp_val < el),
    (channel == ch_external) && (temp_val > eh),
    (channel == ch_internal) && (temp_val < il),
    (channel == ch_internal) && (temp_val > ih)};
  wire [1:0] supply_hits = {
    (channel == ch_supply) && (sample[9:2] < supply_limit_low),
    (channel == ch_supply) && (sample[9:2] > supply_limit_high)};
  wire [3:0] temp_set = storing ? (temp_hits & ~temp_flag_mask) : 4'h0;
  wire [1:0] supply_set = storing ? (supply_hits & ~supply_flag_mask) : 2'h0;
  wire read_temp_flags = reg_read && (reg_addr == `ADDR_TEMP_FLAGS);
  wire read_supply_flags = reg_read && (reg_addr == `ADDR_SUPPLY_FLAGS);

  // sticky flags clear on read; a new event in the same cycle wins
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      temp_flags <= 4'h0;
      supply_flags <= 2'h0;
    end else begin
      temp_flags <= (read_temp_flags ? 4'h0 : temp_flags) | temp_set;
      supply_flags <= (read_supply_flags ? 2'h0 : supply_flags) | supply_set;
    end
  end

  // alert level follows the configured polarity
  wire any_flag = |(temp_flags & ~temp_flag_mask) || |(supply_flags & ~supply_flag_mask);
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      alert <= 1'b0;
    end else begin
      alert <= alert_active_high ? any_flag : !any_flag;
    end
  end

  // split result registers, both halves in one cycle
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      int_high_byte <= 8'h00;
      int_low_bits <= 2'h0;
      ext_high_byte <= 8'h00;
      ext_low_bits <= 2'h0;
      supply_high_byte <= 8'h00;
      supply_low_bits <= 2'h0;
    end else if (storing) begin
      unique case (channel)
        ch_internal: begin
          int_high_byte <= sample[9:2];
          int_low_bits <= sample[1:0];
        end
        ch_external: begin
          ext_high_byte <= sample[9:2];
          ext_low_bits <= sample[1:0];
        end
        ch_supply: begin
          supply_high_byte <= sample[9:2];
          supply_low_bits <= sample[1:0];
        end
        default: begin
          supply_low_bits <= supply_low_bits;
        end
      endcase
    end
  end

  // thermal dac coding for both temperature outputs
  logic [9:0] code_int, code_ext;
  thermal_dac_coder u_code_int (
    .temp(sample),
    .zero_point(int_offset),
    .ten_bit(config3[`BIT_DAC_10BIT]),
    .code(code_int)
  );
  thermal_dac_coder u_code_ext (
    .temp(sample),
    .zero_point(ext_offset),
    .ten_bit(config3[`BIT_DAC_10BIT]),
    .code(code_ext)
  );

  // dac update on each stored temperature when thermal mode is on
  wire load_a = storing && (channel == ch_internal) && config3[`BIT_THERM_A];
  wire load_b = storing && (channel == ch_external) && config3[`BIT_THERM_B];
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      dac_a_code <= 10'h000;
      dac_b_code <= 10'h000;
      dac_a_load <= 1'b0;
      dac_b_load <= 1'b0;
    end else begin
      dac_a_load <= load_a;
      dac_b_load <= load_b;
      if (load_a) begin
        dac_a_code <= code_int;
      end
      if (load_b) begin
        dac_b_code <= code_ext;
      end
    end
  end

  // host writes to control registers
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      config1 <= `CONFIG1_RESET;
      mode_ctrl <= `MODE_CTRL_RESET;
      config3 <= `CONFIG3_RESET;
      int_offset <= `OFFSET_RESET;
      ext_offset <= `OFFSET_RESET;
    end else if (write_hit) begin
      if (reg_addr == `ADDR_CONFIG1) config1 <= reg_wdata;
      if (reg_addr == `ADDR_MODE_CTRL) mode_ctrl <= reg_wdata;
      if (reg_addr == `ADDR_CONFIG3) config3 <= reg_wdata;
      if (reg_addr == `ADDR_INT_OFFSET) int_offset <= reg_wdata;
      if (reg_addr == `ADDR_EXT_OFFSET) ext_offset <= reg_wdata;
    end
  end

  // read data selection, unmapped reads zero
  logic [7:0] read_mux;
  assign read_mux =
    (reg_addr == `ADDR_TEMP_FLAGS) ? {4'h0, temp_flags} :
    (reg_addr == `ADDR_LOW_BITS) ? {4'h0, int_low_bits, supply_low_bits} :
    (reg_addr == `ADDR_EXT_LOW_BITS) ? {6'h00, ext_low_bits} :
    (reg_addr == `ADDR_SUPPLY_HIGH) ? supply_high_byte :
    (reg_addr == `ADDR_INT_HIGH) ? int_high_byte :
    (reg_addr == `ADDR_EXT_HIGH) ? ext_high_byte :
    (reg_addr == `ADDR_SUPPLY_FLAGS) ? {6'h00, supply_flags} :
    (reg_addr == `ADDR_CONFIG1) ? config1 :
    (reg_addr == `ADDR_MODE_CTRL) ? mode_ctrl :
    (reg_addr == `ADDR_CONFIG3) ? config3 :
    (reg_addr == `ADDR_INT_OFFSET) ? int_offset :
    (reg_addr == `ADDR_EXT_OFFSET) ? ext_offset : 8'h00;

  // read data registered on the read strobe
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      reg_rdata <= 8'h00;
    end else if (reg_read) begin
      reg_rdata <= read_mux;
    end
  end
endmodule

// file: design/monitor_defines.svh
// offsets, field positions, reset values and timing figures of the monitor
`ifndef MONITOR_DEFINES_SVH
`define MONITOR_DEFINES_SVH
`define ADDR_TEMP_FLAGS 8'h00
`define ADDR_LOW_BITS 8'h03
`define ADDR_EXT_LOW_BITS 8'h04
`define ADDR_SUPPLY_HIGH 8'h06
`define ADDR_INT_HIGH 8'h07
`define ADDR_EXT_HIGH 8'h08
`define ADDR_SUPPLY_FLAGS 8'h10
`define ADDR_CONFIG1 8'h18
`define ADDR_MODE_CTRL 8'h19
`define ADDR_CONFIG3 8'h1a
`define ADDR_INT_OFFSET 8'h21
`define ADDR_EXT_OFFSET 8'h22
`define CONFIG1_RESET 8'h00
`define MODE_CTRL_RESET 8'h00
`define CONFIG3_RESET 8'h00
`define OFFSET_RESET 8'hd8
`define BIT_MONITOR_EN 0
`define BIT_SINGLE_CHANNEL 4
`define BIT_AVG_DISABLE 5
`define BIT_DAC_10BIT 1
`define BIT_THERM_A 5
`define BIT_THERM_B 6
`define CLK_PERIOD_NS 5.0
`define INT_CONV_US 712.0
`define EXT_CONV_MS 1.51
`define SUPPLY_CONV_US 712.0
`endif

// file: design/monitor_pkg.sv
// types shared by the monitor sequencer and its helpers
package monitor_pkg;
  typedef enum logic [2:0] {
    st_idle = 3'b001,
    st_conv = 3'b010,
    st_store = 3'b100
  } seq_state_type;
  typedef enum logic [1:0] {
    ch_supply = 2'b00,
    ch_internal = 2'b01,
    ch_external = 2'b10
  } channel_type;
endpackage

// file: design/sample_averager.sv
// accumulator that averages a fixed count of signed conversion results
module sample_averager #(
  parameter int SAMPLES = 16,
  parameter int WIDTH = 10
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic clear,
  input wire logic add,
  input wire logic signed [WIDTH-1:0] sample,
  output logic last,
  output logic signed [WIDTH-1:0] mean
);
  localparam int SHIFT = $clog2(SAMPLES);
  logic signed [WIDTH+SHIFT-1:0] acc;
  logic signed [WIDTH+SHIFT-1:0] total;
  logic [SHIFT-1:0] count;

  initial begin
    if (SAMPLES < 2 || (1 << SHIFT) != SAMPLES) $error("SAMPLES must be a power of two");
  end

  // running total including the sample being added now
  assign total = acc + (WIDTH+SHIFT)'(sample);
  assign last = (count == SHIFT'(SAMPLES - 1));
  assign mean = WIDTH'(total >>> SHIFT);

  // accumulate, restart on clear or after the last sample
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      acc <= '0;
      count <= '0;
    end else if (clear || (add && last)) begin
      acc <= '0;
      count <= '0;
    end else if (add) begin
      acc <= total;
      count <= count + 1'b1;
    end
  end
endmodule

// file: design/thermal_dac_coder.sv
// temperature to thermal dac code, clamped at both ends of the span
module thermal_dac_coder (
  input wire logic signed [9:0] temp,
  input wire logic [7:0] zero_point,
  input wire logic ten_bit,
  output logic [9:0] code
);
  logic signed [11:0] diff;
  logic signed [11:0] steps;

  // zero point in whole degrees, scaled to quarter degrees; a set top bit marks a negative start
  assign diff = 12'(temp) - 12'({{2{zero_point[7]}}, zero_point, 2'b00});
  assign steps = ten_bit ? diff : (diff >>> 2);
  // below zero gives 0; past the span the code sticks at full scale
  assign code = steps[11] ? 10'h000 :
                ten_bit ? ((steps > 12'sh3ff) ? 10'h3ff : steps[9:0]) :
                ((steps > 12'sh0ff) ? 10'h0ff : {2'b00, steps[7:0]});
endmodule

// file: verification/monitor_checker.sv
// port assertions for the monitor sequencer
module monitor_checker (
  input wire logic ref_clk,
  input wire logic rstn,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_write,
  input wire logic reg_read,
  input wire logic [7:0] reg_rdata,
  input wire logic txn_active,
  input wire logic adc_convert,
  input wire logic adc_reset,
  input wire monitor_pkg::channel_type adc_channel,
  input wire logic dac_a_load,
  input wire logic dac_b_load
);
  timeunit 1ns;
  timeprecision 100ps;
  import monitor_pkg::*;
  logic [7:0] last_mode;
  logic en_written;
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (!rstn);
  // shadow of the last mode register write
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) last_mode <= 8'h00;
    else if (reg_write && !reg_read && reg_addr == 8'h19) last_mode <= reg_wdata;
  end
  // shadow of the monitor enable bit
  always_ff @(posedge ref_clk or negedge rstn) begin
    if (!rstn) en_written <= 1'b0;
    else if (reg_write && !reg_read && reg_addr == 8'h18) en_written <= reg_wdata[0];
  end
  // shortest conversion of any channel
  sequence conv_run;
    adc_convert [*4];
  endsequence
  sequence mode_read;
    reg_read && !reg_write && reg_addr == 8'h19;
  endsequence
  a_abort_idle: assert property (
    txn_active [*2] |-> ##1 (adc_reset && !adc_convert))
    else $error("conversion kept running during a transaction");
  a_abort_quiet: assert property (
    txn_active [*4] |-> !dac_a_load && !dac_b_load)
    else $error("result loaded during a transaction");
  a_start_clear: assert property (
    $rose(adc_convert) |-> !$past(txn_active))
    else $error("conversion started inside a transaction");
  a_conv_span: assert property (
    $rose(adc_convert) |-> (conv_run or (##[0:4] txn_active)))
    else $error("conversion ended too early");
  a_channel_hold: assert property (
    adc_convert && $past(adc_convert) |-> $stable(adc_channel))
    else $error("channel changed inside a conversion");
  a_gap_restart: assert property (
    $fell(adc_convert) |-> ##[1:3] (adc_convert || adc_reset))
    else $error("next conversion did not follow");
  a_load_pulse: assert property (
    dac_a_load || dac_b_load |=> !dac_a_load && !dac_b_load)
    else $error("dac load longer than one cycle");
  a_conv_exclusive: assert property (
    adc_convert |-> !adc_reset && en_written)
    else $error("adc converting while held in reset or not enabled");
  a_mode_readback: assert property (
    mode_read |=> reg_rdata == last_mode)
    else $error("mode register read back wrong");
endmodule

// file: verification/adc_model.sv
// behavioural adc answering the sequencer's conversions
module adc_model (
  input wire logic ref_clk,
  input wire logic adc_convert,
  input wire monitor_pkg::channel_type adc_channel,
  input wire logic [9:0] supply_val,
  input wire logic [9:0] int_val,
  input wire logic [9:0] ext_val,
  output logic [9:0] adc_data
);
  timeunit 1ns;
  timeprecision 100ps;
  import monitor_pkg::*;
  logic [9:0] picked;
  // result of the channel under conversion
  assign picked = adc_channel == ch_supply ? supply_val :
                  adc_channel == ch_internal ? int_val : ext_val;
  // idle bus toggles so stale data never looks valid
  always_ff @(posedge ref_clk) begin
    if (adc_convert) adc_data <= picked;
    else adc_data <= ~adc_data;
  end
endmodule

// file: verification/monitor_sequencer_limit_check_tb.sv
// self-checking bench for the monitor sequencer
bind monitor_sequencer monitor_checker monitor_checker_i (.ref_clk, .rstn, .reg_addr, .reg_wdata,
  .reg_write, .reg_read, .reg_rdata, .txn_active, .adc_convert, .adc_reset, .adc_channel,
  .dac_a_load, .dac_b_load);
module monitor_sequencer_limit_check_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import monitor_pkg::*;
  logic ref_clk, rstn, reg_write, reg_read, txn_active, adc_convert, adc_reset, alert;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, supply_limit_high, supply_limit_low;
  logic signed [7:0] int_limit_high, int_limit_low, ext_limit_high, ext_limit_low;
  logic [3:0] temp_flag_mask;
  logic [1:0] supply_flag_mask;
  logic alert_active_high, dac_a_load, dac_b_load;
  logic [9:0] adc_data, dac_a_code, dac_b_code, supply_val, int_val, ext_val, got;
  channel_type adc_channel;
  int n_errors, total_checks;
  monitor_sequencer #(.INT_CONV_CYCLES(4), .EXT_CONV_CYCLES(6), .SUPPLY_CONV_CYCLES(5),
    .AVG_SAMPLES(16)) monitor_sequencer_i (.ref_clk, .rstn, .reg_addr, .reg_wdata, .reg_write,
    .reg_read, .reg_rdata, .txn_active, .adc_convert, .adc_reset, .adc_channel, .adc_data,
    .int_limit_high, .int_limit_low, .ext_limit_high, .ext_limit_low, .supply_limit_high,
    .supply_limit_low, .temp_flag_mask, .supply_flag_mask, .alert_active_high, .alert,
    .dac_a_code, .dac_b_code, .dac_a_load, .dac_b_load);
  adc_model adc_model_i (.ref_clk, .adc_convert, .adc_channel, .supply_val, .int_val,
    .ext_val, .adc_data);
  // free-running clock
  initial begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  task chk(input string what, input logic [9:0] exp, input logic [9:0] seen);
    total_checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge ref_clk);
    reg_write <= 1'b0;
  endtask
  task rd(input logic [7:0] a);
    @(posedge ref_clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge ref_clk);
    reg_read <= 1'b0;
    #1;
    got = {2'b00, reg_rdata};
  endtask
  // waits for n finished results; mode 1 checks one channel, mode 2 the ring
  task automatic ends(input int n, input int mode, input logic [1:0] want);
    int k;
    logic was, have;
    logic [1:0] nx;
    k = 0;
    have = 1'b0;
    #1;
    was = adc_convert;
    while (n > 0 && k < 4000) begin
      @(posedge ref_clk);
      #1;
      if (mode == 1 && adc_convert) chk("channel", 10'(want), 10'(adc_channel));
      if (mode == 2 && !was && adc_convert) begin
        if (have) chk("ring", 10'(nx), 10'(adc_channel));
        have = 1'b1;
        nx = adc_channel == 2'd2 ? 2'd0 : 2'(adc_channel + 2'd1);
      end
      if (was && !adc_convert) n--;
      was = adc_convert;
      k++;
    end
    chk("ends", 10'h000, 10'(n));
    repeat (3) @(posedge ref_clk);
    #1;
  endtask
  task automatic to_load(output int c);
    c = 0;
    do begin
      @(posedge ref_clk);
      #1;
      c++;
    end while (!dac_a_load && c < 500);
  endtask
  task automatic t_reset;
    int k;
    k = 0;
    repeat (20) begin
      @(posedge ref_clk);
      #1;
      if (adc_convert || !adc_reset) k++;
    end
    chk("idle", 10'h000, 10'(k));
    rd(8'h19);
    chk("mode reset", 10'h000, got);
    rd(8'h18);
    chk("config reset", 10'h000, got);
    rd(8'h05);
    chk("unmapped", 10'h000, got);
    $display("done reset");
  endtask
  task t_supply;
    supply_val = 10'h2de;
    wr(8'h19, 8'h30);
    wr(8'h18, 8'h01);
    ends(2, 0, 2'd0);
    ends(3, 1, 2'd0);
    rd(8'h06);
    chk("supply high", 10'h0b7, got);
    rd(8'h03);
    chk("supply low", 10'h002, got & 10'h003);
    @(posedge ref_clk);
    supply_limit_high <= 8'ha0;
    ends(2, 0, 2'd0);
    chk("alert on", 10'h001, 10'(alert));
    @(posedge ref_clk);
    alert_active_high <= 1'b0;
    repeat (2) @(posedge ref_clk);
    #1;
    chk("alert low", 10'h000, 10'(alert));
    @(posedge ref_clk);
    supply_limit_high <= 8'hff;
    ends(2, 0, 2'd0);
    rd(8'h10);
    chk("supply flag", 10'h001, got);
    rd(8'h10);
    chk("flag cleared", 10'h000, got);
    repeat (2) @(posedge ref_clk);
    #1;
    chk("alert idle", 10'h001, 10'(alert));
    @(posedge ref_clk);
    alert_active_high <= 1'b1;
    $display("done supply");
  endtask
  task t_internal;
    int_val = 10'h064;
    @(posedge ref_clk);
    int_limit_high <= 8'sd20;
    wr(8'h21, 8'h0a);
    wr(8'h1a, 8'h20);
    wr(8'h19, 8'h31);
    ends(2, 0, 2'd0);
    ends(2, 1, 2'd1);
    rd(8'h07);
    chk("int high", 10'h019, got);
    chk("dac a 8-bit", 10'h00f, dac_a_code);
    rd(8'h00);
    chk("temp flag", 10'h001, got);
    @(posedge ref_clk);
    temp_flag_mask <= 4'h1;
    rd(8'h00);
    ends(2, 0, 2'd0);
    rd(8'h00);
    chk("masked flag", 10'h000, got);
    wr(8'h1a, 8'h22);
    ends(2, 0, 2'd0);
    chk("dac a 10-bit", 10'h03c, dac_a_code);
    int_val = 10'h1ff;
    wr(8'h21, 8'h80);
    ends(2, 0, 2'd0);
    chk("dac a top", 10'h3ff, dac_a_code);
    int_val = 10'h064;
    @(posedge ref_clk);
    int_limit_high <= 8'sd127;
    temp_flag_mask <= 4'h0;
    $display("done internal");
  endtask
  task automatic t_avg;
    int p;
    wr(8'h19, 8'h11);
    to_load(p);
    to_load(p);
    chk("avg span", 10'h001, 10'(p >= 64 && p <= 68));
    wr(8'h19, 8'h31);
    to_load(p);
    to_load(p);
    chk("single span", 10'h001, 10'(p <= 8));
    $display("done average");
  endtask
  task t_rr;
    ext_val = 10'h3d8;
    wr(8'h1a, 8'h40);
    wr(8'h19, 8'h20);
    ends(3, 0, 2'd0);
    ends(5, 2, 2'd0);
    rd(8'h08);
    chk("ext high", 10'h0f6, got);
    chk("dac b", 10'h01e, dac_b_code);
    $display("done round robin");
  endtask
  task automatic t_abort;
    int k;
    k = 0;
    ext_val = 10'h064;
    while (!adc_convert && k < 50) begin
      @(posedge ref_clk);
      #1;
      k++;
    end
    chk("busy", 10'h001, 10'(adc_convert));
    @(posedge ref_clk);
    txn_active <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("abort", 10'h002, {8'h00, adc_reset, adc_convert});
    repeat (30) @(posedge ref_clk);
    rd(8'h08);
    chk("kept result", 10'h0f6, got);
    @(posedge ref_clk);
    txn_active <= 1'b0;
    repeat (3) @(posedge ref_clk);
    #1;
    chk("restart", 10'h001, 10'(adc_convert));
    $display("done abort");
  endtask
  task wrap_up;
    $display("checks %0d mismatches %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // watchdog against a hang
  initial begin
    repeat (30000) @(posedge ref_clk);
    n_errors++;
    wrap_up;
  end
  // reset, then the scenarios in order
  initial begin
    n_errors = 0;
    total_checks = 0;
    rstn = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_write = 1'b0;
    reg_read = 1'b0;
    txn_active = 1'b0;
    int_limit_high = 8'sd127;
    int_limit_low = -8'sd128;
    ext_limit_high = 8'sd127;
    ext_limit_low = -8'sd128;
    supply_limit_high = 8'hff;
    supply_limit_low = 8'h00;
    temp_flag_mask = 4'h0;
    supply_flag_mask = 2'h0;
    alert_active_high = 1'b1;
    supply_val = 10'h000;
    int_val = 10'h000;
    ext_val = 10'h000;
    repeat (5) @(posedge ref_clk);
    rstn <= 1'b1;
    repeat (3) @(posedge ref_clk);
    #1;
    t_reset;
    t_supply;
    t_internal;
    t_avg;
    t_rr;
    t_abort;
    wrap_up;
  end
endmodule
